// [rtl/domain_mask.v]
// decodes a sleep mode into the set of domains kept running
`timescale 1ns/1ps
`default_nettype none
`include "sleep_ctl_regs.vh"
module domain_mask
(
  input  wire [2:0]              mode,
  output reg  [`DOM_WIDTH-1:0]   keep,
  output reg                     valid
);
  // one bit per domain; an unknown code keeps everything alive
  always @*
  begin
    keep  = {`DOM_WIDTH{1'h0}};
    valid = 1'h1;
    case (mode)
      `MODE_IDLE:
      begin
        keep[`DOM_SRAM]     = 1'h1;
        keep[`DOM_TIMER]    = 1'h1;
        keep[`DOM_SPI]      = 1'h1;
        keep[`DOM_IRQ]      = 1'h1;
        keep[`DOM_ADC]      = 1'h1;
        keep[`DOM_ASYNC]    = 1'h1;
        keep[`DOM_MAIN_OSC] = 1'h1;
        keep[`DOM_XTAL]     = 1'h1;
      end
      `MODE_ADC_NR:
      begin
        keep[`DOM_ADC]      = 1'h1;
        keep[`DOM_ASYNC]    = 1'h1;
        keep[`DOM_MAIN_OSC] = 1'h1;
        keep[`DOM_XTAL]     = 1'h1;
      end
      `MODE_PWR_DOWN:
        keep = {`DOM_WIDTH{1'h0}};
      `MODE_PWR_SAVE:
        keep[`DOM_ASYNC]    = 1'h1;
      `MODE_STANDBY:
        keep[`DOM_XTAL]     = 1'h1;
      `MODE_EXT_STBY:
      begin
        keep[`DOM_MAIN_OSC] = 1'h1;
        keep[`DOM_XTAL]     = 1'h1;
        keep[`DOM_ASYNC]    = 1'h1;
      end
      default:
      begin
        keep  = `DOM_ALL_ON;
        valid = 1'h0;
      end
    endcase
  end
endmodule // domain_mask
`default_nettype wire

// [rtl/sleep_ctl_regs.vh]
// constants for the sleep mode controller
`ifndef SLEEP_CTL_REGS_VH
`define SLEEP_CTL_REGS_VH
// mode select encodings
`define MODE_IDLE       3'h0
`define MODE_ADC_NR     3'h1
`define MODE_PWR_DOWN   3'h2
`define MODE_PWR_SAVE   3'h3
`define MODE_STANDBY    3'h6
`define MODE_EXT_STBY   3'h7
// bit positions in the domain enable vector
`define DOM_CPU         0
`define DOM_SRAM        1
`define DOM_TIMER       2
`define DOM_SPI         3
`define DOM_IRQ         4
`define DOM_ADC         5
`define DOM_ASYNC       6
`define DOM_MAIN_OSC    7
`define DOM_XTAL        8
`define DOM_WIDTH       9
`define DOM_ALL_ON      9'h1FF
`define MODE_RESET      3'h0
// wake request lines, in the order they enter the synchroniser
`define WAKE_IRQ        0
`define WAKE_PER        1
`define WAKE_LINES      2
`endif

// [rtl/sleep_mode_controller.v]
// sleep mode controller: mode hold, sleep entry, wake and domain enables
//
// Overview of operation
// - six selectable sleep modes, each gating domains
// - idle halts cpu, keeps sram, timers, spi, irq
// - power-down stops oscillator, registers retained
// - power-down exits only on interrupt or reset
// - power-save keeps asynchronous timer counting
// - adc noise mode keeps adc, async timer and both oscillators
// - standby keeps crystal oscillator running
// - extended standby keeps oscillator and async timer
`timescale 1ns/1ps
`default_nettype none
`include "sleep_ctl_regs.vh"
module sleep_mode_controller
(
  input  wire                    mclk,
  input  wire                    rst,
  input  wire [2:0]              mode_wdata,
  input  wire                    mode_we,
  input  wire                    sleep_cmd,
  input  wire                    irq_wake,
  input  wire                    periph_wake,
  output reg  [2:0]              mode_sel,
  output reg                     asleep,
  output reg  [`DOM_WIDTH-1:0]   dom_en,
  output reg                     wake_pulse
);
  // one-hot states: running, or parked in the stored sleep mode
  localparam ST_RUN   = 2'h1;
  localparam ST_SLEEP = 2'h2;

  // controller state and the values loaded on the next edge
  reg  [1:0]              state;
  reg  [1:0]              next_state;
  reg  [2:0]              next_mode_sel;
  reg                     next_asleep;
  reg  [`DOM_WIDTH-1:0]   next_dom_en;
  reg                     next_wake_pulse;

  // raw and synchronised wake requests, one bit per line
  wire [`WAKE_LINES-1:0]  wake_raw;
  wire [`WAKE_LINES-1:0]  wake_seen;
  wire                    irq_seen;
  wire                    per_seen;

  // mode decode results and the entry and exit qualifiers
  wire [`DOM_WIDTH-1:0]   keep;
  wire                    mode_ok;
  reg                     wake_ok;
  wire                    enter_ok;

  // the decoder works on the stored mode, never on the write data,
  // so a write and a sleep command in one cycle cannot mix codes
  domain_mask domain_mask_i
  (
    .mode  (mode_sel),
    .keep  (keep),
    .valid (mode_ok)
  );

  // gather the wake lines so one loop can synchronise them all
  assign wake_raw[`WAKE_IRQ] = irq_wake;
  assign wake_raw[`WAKE_PER] = periph_wake;

  // wake lines come from logic that may run off other clocks, so
  // each passes two flip-flops; only the second one is read
  genvar gi;
  generate
    for (gi = 0; gi < `WAKE_LINES; gi = gi + 1)
    begin : wake_sync
      reg stage1;
      reg stage2;
      always @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          stage1 <= 1'h0;
          stage2 <= 1'h0;
        end
        else
        begin
          stage1 <= wake_raw[gi];
          stage2 <= stage1;
        end
      end
      assign wake_seen[gi] = stage2;
    end
  endgenerate

  // named views of the synchronised lines
  assign irq_seen = wake_seen[`WAKE_IRQ];
  assign per_seen = wake_seen[`WAKE_PER];

  // power-down ignores peripheral events; others accept either.
  // wake is level based, so a line held high keeps the part awake
  always @*
  begin
    if (mode_sel == `MODE_PWR_DOWN)
      wake_ok = irq_seen;
    else
      wake_ok = irq_seen | per_seen;
  end

  // a sleep command is refused with a write in the same cycle, with
  // an undefined code, or while a wake is already pending; nothing
  // flags the refusal, software simply sees asleep stay low
  assign enter_ok = sleep_cmd & ~mode_we & mode_ok & ~wake_ok;

  // next values; mode writes while asleep are dropped since the
  // cpu is halted and cannot issue them
  always @*
  begin
    next_state      = state;
    next_mode_sel   = mode_sel;
    next_asleep     = asleep;
    next_dom_en     = dom_en;
    next_wake_pulse = 1'h0;
    case (state)
      ST_RUN:
      begin
        if (mode_we)
          next_mode_sel = mode_wdata;
        if (enter_ok)
        begin
          next_state  = ST_SLEEP;
          next_asleep = 1'h1;
          next_dom_en = keep;
        end
      end
      ST_SLEEP:
      begin
        // stopped domains keep their contents; only enables move
        if (wake_ok)
        begin
          next_state      = ST_RUN;
          next_asleep     = 1'h0;
          next_dom_en     = `DOM_ALL_ON;
          next_wake_pulse = 1'h1;
        end
      end
      default:
      begin
        // a corrupted state falls back to running with all on
        next_state  = ST_RUN;
        next_asleep = 1'h0;
        next_dom_en = `DOM_ALL_ON;
      end
    endcase
  end

  // every output is a flip-flop, so the gating cells downstream
  // never see decode glitches
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state      <= ST_RUN;
      mode_sel   <= `MODE_RESET;
      asleep     <= 1'h0;
      dom_en     <= `DOM_ALL_ON;
      wake_pulse <= 1'h0;
    end
    else
    begin
      state      <= next_state;
      mode_sel   <= next_mode_sel;
      asleep     <= next_asleep;
      dom_en     <= next_dom_en;
      wake_pulse <= next_wake_pulse;
    end
  end
endmodule // sleep_mode_controller
`default_nettype wire

// [tb/sleep_chk_assertions.sv]
// assertions for the sleep mode controller
`timescale 1ns/1ps
`default_nettype none
module sleep_chk
(
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       mode_we,
  input wire logic       sleep_cmd,
  input wire logic       irq_wake,
  input wire logic       periph_wake,
  input wire logic [2:0] mode_sel,
  input wire logic       asleep,
  input wire logic [8:0] dom_en,
  input wire logic       wake_pulse
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // entry needs quiet wake lines, since a held wake blocks sleep
  sleep_entry_a: assert property (
    (!irq_wake && !periph_wake)[*3] ##0 !asleep && sleep_cmd && !mode_we
    && mode_sel[2:1] != 2'h2 |=> asleep) else $error("entry");
  bad_code_a: assert property (
    !asleep && sleep_cmd && mode_sel[2:1] == 2'h2 |=> !asleep)
    else $error("code");
  awake_all_a: assert property (!asleep |-> dom_en == 9'h1FF)
    else $error("awake");
  wake_done_a: assert property (
    wake_pulse |-> $past(asleep) && dom_en == 9'h1FF) else $error("wake");
  idle_set_a: assert property (
    asleep && mode_sel == 3'h0 |-> dom_en[4:0] == 5'h1E) else $error("idle");
  pd_off_a: assert property (
    asleep && mode_sel == 3'h2 |-> dom_en == 9'h000) else $error("pd");
  pd_hold_a: assert property (
    (asleep && mode_sel == 3'h2 && !irq_wake)[*3] |=> asleep)
    else $error("hold");
  irq_exit_a: assert property (
    asleep && irq_wake |-> ##[1:3] !asleep) else $error("exit");
endmodule // sleep_chk
bind sleep_mode_controller sleep_chk sleep_chk_i (.mclk, .rst, .mode_we,
  .sleep_cmd, .irq_wake, .periph_wake, .mode_sel, .asleep, .dom_en,
  .wake_pulse);
`default_nettype wire

// [tb/sleep_mode_controller_tb.sv]
// self-checking testbench for the sleep mode controller
`timescale 1ns/1ps
`default_nettype none
module sleep_mode_controller_tb;
  logic       mclk = 1'h0, rst = 1'h1, mode_we = 1'h0, sleep_cmd = 1'h0;
  logic       irq_wake = 1'h0, periph_wake = 1'h0, asleep, wake_pulse;
  logic [2:0] mode_wdata = 3'h0, mode_sel;
  logic [8:0] dom_en;
  int         err_count = 0, total_checks = 0, cyc = 0;
  sleep_mode_controller sleep_mode_controller_i (.mclk, .rst, .mode_wdata,
    .mode_we, .sleep_cmd, .irq_wake, .periph_wake, .mode_sel, .asleep,
    .dom_en, .wake_pulse);
  // 50 ns clock; guard far past the 114 cycles needed
  always #25 mclk = ~mclk;
  always @(posedge mclk)
    if (++cyc == 2000)
    begin
      err_count++;
      print_verdict();
    end
  // compare and count
  task chk(input string n, input logic [9:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  // store a mode, sleep, try a side wake in power-down only, then wake by interrupt
  task go(input logic [2:0] m, input logic [9:0] mk, ex, input logic p);
    repeat (4) @(negedge mclk);
    mode_wdata = m;
    mode_we = 1'h1;
    @(negedge mclk) mode_we = 1'h0;
    chk("mode_sel", {7'h0, m}, {7'h0, mode_sel});
    sleep_cmd = 1'h1;
    @(negedge mclk) sleep_cmd = 1'h0;
    chk("asleep", {9'h0, p}, {9'h0, asleep});
    periph_wake = (m == 3'h2);
    repeat (4) @(negedge mclk);
    chk("dom_en", ex, {1'h0, dom_en} & mk);
    periph_wake = 1'h0;
    irq_wake = 1'h1;
    repeat (3) @(negedge mclk);
    chk("wake", {p, 9'h1FF}, {wake_pulse, dom_en});
    @(negedge mclk) chk("awake", 10'h0, {wake_pulse, 8'h0, asleep});
    irq_wake = 1'h0;
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // reset, then every mode and one refused code
  initial
  begin
    repeat (16) @(negedge mclk);
    rst = 1'h0;
    chk("reset", 10'h1FF, {1'h0, dom_en});
    go(3'h0, 10'h01F, 10'h01E, 1'h1);
    go(3'h1, 10'h07F, 10'h060, 1'h1);
    go(3'h2, 10'h1FF, 10'h000, 1'h1);
    go(3'h3, 10'h07F, 10'h040, 1'h1);
    go(3'h6, 10'h17F, 10'h100, 1'h1);
    go(3'h7, 10'h0FF, 10'h0C0, 1'h1);
    go(3'h4, 10'h1FF, 10'h1FF, 1'h0);
    print_verdict();
  end
endmodule // sleep_mode_controller_tb
`default_nettype wire
